// ---- rtl/wdthc_top.sv ----
// Purpose: Watchdog down-counter with exact step timing and halt-mode handling
// Assumes: APB slave on pclk; CPU halt and wake events arrive as one-cycle pulses
// Notes: Reset request out is a one-cycle pulse; the system turns it into presetn
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps

module wdthc_top
  import wdthc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic halt_req,
  input wire logic ext_irq,
  input wire logic tb_irq,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic wdg_reset
);

  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic wdg_rst_q;
  logic act_q;
  logic [6:0] cnt_q;
  logic top_prev_q;
  logic [13:0] presc_q;
  logic [13:0] step_q;
  logic [5:0] long_left_q;
  logic [11:0] start_q;
  logic [11:0] start_cyc_q;
  wdthc_cfg_t cfg_q;
  wdthc_mode_t mode_q;

  logic [5:0] coarse;
  logic [5:0] fine;
  logic active;
  logic run;
  logic access;
  logic wr_ctrl;
  logic wr_cfg;
  logic halt_freeze;
  logic halt_reset;
  logic halt_ahalt;
  logic step_end;
  logic [14:0] remain;
  logic [14:0] min0;
  logic [13:0] first_load;
  logic [13:0] long_load;
  logic [7:0] quot;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign wdg_reset = wdg_rst_q;

  // Per time-base constants
  always_comb begin
    case (cfg_q.tb)
      2'b00: begin
        coarse = COARSE_TB0;
        fine = FINE_TB0;
      end
      2'b01: begin
        coarse = COARSE_TB1;
        fine = FINE_TB1;
      end
      2'b10: begin
        coarse = COARSE_TB2;
        fine = FINE_TB2;
      end
      default: begin
        coarse = COARSE_TB3;
        fine = FINE_TB3;
      end
    endcase
  end

  assign active = act_q | cfg_q.hw_wdg;
  assign run = (mode_q == ST_RUN);
  assign access = psel & penable & pready_q;
  assign wr_ctrl = access & pwrite & (paddr == OFS_CTRL);
  assign wr_cfg = access & pwrite & (paddr == OFS_CFG);
  assign halt_freeze = run & halt_req & ~cfg_q.irq_en & ~cfg_q.halt_rst;
  assign halt_reset = run & halt_req & ~cfg_q.irq_en & cfg_q.halt_rst;
  assign halt_ahalt = run & halt_req & cfg_q.irq_en;
  // Step boundary as the counter block sees it
  assign step_end = run & ~wr_ctrl & ~halt_freeze & ~halt_ahalt & (step_q == 14'h0000);

  // First step ends at the prescaler wrap, never sooner than the fine minimum
  assign remain = 15'(STEP_FULL) - {1'b0, presc_q};
  assign min0 = 15'(({9'h000, fine} + 15'(MIN0_BASE)) * 15'(FINE_MULT));
  assign first_load = (remain < min0) ? 14'(min0 - 15'd1) : 14'(remain - 15'd1);
  assign long_load = 14'((({8'h00, fine} + 14'(LONG_BASE)) * 14'(FINE_MULT)) - 14'd1);
  // Integer divide truncates; zero whenever count is below coarse/4
  assign quot = {pwdata[5:0], 2'b00} / {2'b00, coarse};

  // Shared prescaler is never restarted by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= 14'h0000;
    end else begin
      presc_q <= presc_q + 14'h0001;
    end
  end

  // Activation can only be set; reset is the only way back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_q <= CTRL_RESET[ACT_BIT];
    end else if (wr_ctrl && run && pwdata[ACT_BIT]) begin
      act_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= CFG_RESET;
    end else if (wr_cfg) begin
      cfg_q <= pwdata[5:0];
    end
  end

  // Counter and step timing; clock slowing or wait never gate it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= CTRL_RESET[6:0];
      step_q <= STEP_FULL_LOAD;
      long_left_q <= 6'h00;
    end else if (wr_ctrl && run) begin
      cnt_q <= pwdata[6:0];
      step_q <= first_load;
      long_left_q <= quot[5:0];
    end else if (halt_freeze) begin
      cnt_q <= cnt_q - 7'h01;
    end else if (run && !halt_ahalt) begin
      if (step_q == 14'h0000) begin
        cnt_q <= cnt_q - 7'h01;
        if (long_left_q != 6'h00) begin
          step_q <= long_load;
          long_left_q <= long_left_q - 6'h01;
        end else begin
          step_q <= STEP_FULL_LOAD;
        end
      end else begin
        step_q <= step_q - 14'h0001;
      end
    end
  end

  // Reset request: top bit falling while active and running, or halt option
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      top_prev_q <= CTRL_RESET[TOP_BIT];
      wdg_rst_q <= 1'b0;
    end else begin
      top_prev_q <= cnt_q[TOP_BIT];
      wdg_rst_q <= (top_prev_q & ~cnt_q[TOP_BIT] & active & run) | halt_reset;
    end
  end

  // Power-mode sequencing; leaving reset counts as a reset exit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= ST_START;
      start_q <= START_SHORT_LOAD;
    end else begin
      case (mode_q)
        ST_RUN: begin
          if (halt_ahalt) begin
            mode_q <= ST_AHALT;
          end else if (halt_freeze) begin
            mode_q <= ST_FROZEN;
          end
        end
        ST_AHALT: begin
          if (tb_irq || ext_irq) begin
            mode_q <= ST_RUN;
          end
        end
        ST_FROZEN: begin
          if (ext_irq) begin
            mode_q <= ST_START;
            start_q <= cfg_q.long_start ? START_LONG_LOAD : START_SHORT_LOAD;
          end
        end
        ST_START: begin
          if (start_q == 12'h000) begin
            mode_q <= ST_RUN;
          end else begin
            start_q <= start_q - 12'h001;
          end
        end
        default: begin
          mode_q <= ST_RUN;
        end
      endcase
    end
  end

  // APB: answer in the first access cycle; unmapped offsets take an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready_q <= 1'b1;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      case (paddr)
        OFS_CTRL: begin
          prdata_q <= {24'h00_0000, act_q, cnt_q};
        end
        OFS_CFG: begin
          prdata_q <= {26'h000_0000, cfg_q};
        end
        OFS_STAT: begin
          prdata_q <= {20'h0_0000, start_q[11:0]} | {28'h000_0000, active, mode_q, 1'b0} << 12;
        end
        default: begin
          pslverr_q <= 1'b1;
        end
      endcase
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  chk_act_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    !$fell(act_q))
    else $error("activation bit cleared without reset");

  chk_top_reset: assert property (@(posedge pclk) disable iff (!presetn)
    ($fell(cnt_q[TOP_BIT]) && active && run) |=> wdg_rst_q)
    else $error("no reset after top count bit cleared");

  chk_hw_option: assert property (@(posedge pclk) disable iff (!presetn)
    ($fell(cnt_q[TOP_BIT]) && cfg_q.hw_wdg && !act_q && run) |=> wdg_rst_q)
    else $error("hardware option did not force reset");

  chk_halt_reset: assert property (@(posedge pclk) disable iff (!presetn)
    (run && halt_req && !cfg_q.irq_en && cfg_q.halt_rst) |=> wdg_rst_q)
    else $error("halt with halt-reset option gave no reset");

  chk_frozen_once: assert property (@(posedge pclk) disable iff (!presetn)
    halt_freeze |=> (mode_q == ST_FROZEN) && (cnt_q == $past(cnt_q) - 7'h01) ##1 !wdg_rst_q)
    else $error("frozen halt did not decrement exactly once");

  chk_frozen_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q == ST_FROZEN) |=> $stable(cnt_q) && !wdg_rst_q)
    else $error("counter moved or reset while frozen");

  chk_ahalt_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (run && halt_req && cfg_q.irq_en) |=> (mode_q == ST_AHALT) && $stable(cnt_q))
    else $error("active-halt entry changed counter");

  chk_ahalt_wake: assert property (@(posedge pclk) disable iff (!presetn)
    ((mode_q == ST_AHALT) && (tb_irq || ext_irq)) |=> run)
    else $error("active-halt wake was not immediate");

  chk_wake_delay: assert property (@(posedge pclk) disable iff (!presetn)
    ((mode_q == ST_FROZEN) && ext_irq && !cfg_q.long_start)
      |=> ##255 (mode_q == ST_START) ##1 run)
    else $error("short start-up delay is not 256 clocks");

  chk_start_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q == ST_START) |=> $stable(cnt_q))
    else $error("counter moved during start-up delay");

  chk_first_step: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && run) |=> (step_q <= STEP_FULL_LOAD) && ({1'b0, step_q} >= min0 - 15'd1))
    else $error("first step outside its bounds");

  chk_ahalt_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q == ST_AHALT) |=> $stable(cnt_q) && !wdg_rst_q)
    else $error("counter moved or reset during active-halt");

  chk_long_step: assert property (@(posedge pclk) disable iff (!presetn)
    (step_end && (long_left_q != 6'h00))
      |=> (({1'b0, step_q} + 15'h0001) == 15'(({9'h000, $past(fine)} + 15'(LONG_BASE)) * 15'(FINE_MULT))))
    else $error("long step has the wrong length");

  chk_full_step: assert property (@(posedge pclk) disable iff (!presetn)
    (step_end && (long_left_q == 6'h00)) |=> (step_q == STEP_FULL_LOAD))
    else $error("full step has the wrong length");

  chk_step_dec: assert property (@(posedge pclk) disable iff (!presetn)
    step_end |=> (cnt_q == $past(cnt_q) - 7'h01))
    else $error("counter did not decrement at step end");

  chk_idle_norst: assert property (@(posedge pclk) disable iff (!presetn)
    ($fell(cnt_q[TOP_BIT]) && !active && !halt_reset) |=> !wdg_rst_q)
    else $error("inactive watchdog requested a reset");

  chk_act_set: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && run && pwdata[ACT_BIT]) |=> act_q)
    else $error("activation write did not set the bit");

  chk_long_count: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && run) |=>
      ({6'h00, long_left_q} * {6'h00, $past(coarse)} <= {4'h0, $past(pwdata[5:0]), 2'b00}) &&
      (({6'h00, long_left_q} + 12'h001) * {6'h00, $past(coarse)} >
        {4'h0, $past(pwdata[5:0]), 2'b00}))
    else $error("long-step count is not the truncated quotient");

  chk_frozen_wake: assert property (@(posedge pclk) disable iff (!presetn)
    ((mode_q == ST_FROZEN) && ext_irq) |=> (mode_q == ST_START))
    else $error("external wake did not start the delay");

  chk_start_exit: assert property (@(posedge pclk) disable iff (!presetn)
    ((mode_q == ST_START) && (start_q == 12'h000)) |=> run)
    else $error("start-up delay did not end in run");

  // Cycles spent in start-up, kept only to check its length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_cyc_q <= 12'h000;
    end else if (mode_q == ST_START) begin
      start_cyc_q <= start_cyc_q + 12'h001;
    end else begin
      start_cyc_q <= 12'h000;
    end
  end

  chk_start_len: assert property (@(posedge pclk) disable iff (!presetn)
    ((mode_q == ST_START) && (start_q == 12'h000))
      |-> ((start_cyc_q == START_SHORT_LOAD) || (start_cyc_q == START_LONG_LOAD)))
    else $error("start-up delay is neither 256 nor 4096 clocks");

endmodule

// ---- rtl/wdthc_pkg.sv ----
// Purpose: Shared constants and types for the watchdog timeout and halt control block
// Assumes: pclk is the oscillator clock; all timing counts are in its cycles
// Notes: Register map is word aligned on a 32-bit APB
package wdthc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;

  // Control register layout and reset value
  localparam int ACT_BIT = 7;
  localparam int TOP_BIT = 6;
  localparam logic [7:0] CTRL_RESET = 8'h7f;

  // Configuration register field positions and reset value
  localparam int CFG_TB_LSB = 0;
  localparam int CFG_IRQ_EN_BIT = 2;
  localparam int CFG_HALT_RST_BIT = 3;
  localparam int CFG_HW_WDG_BIT = 4;
  localparam int CFG_LONG_START_BIT = 5;
  localparam logic [5:0] CFG_RESET = 6'h00;

  // Step timing, in oscillator cycles
  localparam int STEP_FULL = 16384;
  localparam int FINE_MULT = 64;
  localparam int MIN0_BASE = 128;
  localparam int LONG_BASE = 192;
  localparam logic [13:0] STEP_FULL_LOAD = 14'(STEP_FULL - 1);

  // Start-up delays, in CPU clocks
  localparam int START_SHORT = 256;
  localparam int START_LONG = 4096;
  localparam logic [11:0] START_SHORT_LOAD = 12'(START_SHORT - 1);
  localparam logic [11:0] START_LONG_LOAD = 12'(START_LONG - 1);

  // Coarse and fine constants per time-base code
  localparam logic [5:0] COARSE_TB0 = 6'h04;
  localparam logic [5:0] COARSE_TB1 = 6'h08;
  localparam logic [5:0] COARSE_TB2 = 6'h14;
  localparam logic [5:0] COARSE_TB3 = 6'h31;
  localparam logic [5:0] FINE_TB0 = 6'h3b;
  localparam logic [5:0] FINE_TB1 = 6'h35;
  localparam logic [5:0] FINE_TB2 = 6'h23;
  localparam logic [5:0] FINE_TB3 = 6'h36;

  typedef struct packed {
    logic long_start;
    logic hw_wdg;
    logic halt_rst;
    logic irq_en;
    logic [1:0] tb;
  } wdthc_cfg_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_AHALT = 2'b01,
    ST_FROZEN = 2'b10,
    ST_START = 2'b11
  } wdthc_mode_t;

endpackage

// ---- bench/wdthc_top_tb.sv ----
// Purpose: Self-checking bench for the watchdog timeout and halt control block
// Assumes: Zero-wait APB slave; mode field in STAT bits 14:13
// Notes: Step timing is measured by polling, so bounds carry a few cycles of slack
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin error_cnt++; \
  $display("mismatch %s exp %0h got %0h", nm, exp, got); end end
module wdthc_top_tb;
  import wdthc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic halt_req = 0, ext_irq = 0, tb_irq = 0, pready, pslverr, wdg_reset, err;
  int error_cnt = 0, compares = 0, cyc = 0, pulses = 0, p0, t0;
  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (wdg_reset === 1'b1) pulses <= pulses + 1;
  end
  wdthc_top u_wdthc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .halt_req(halt_req), .ext_irq(ext_irq),
    .tb_irq(tb_irq), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wdg_reset(wdg_reset));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("mismatch pready exp 1 got %b", pready);
    end
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic pulse_in(input int which);
    @(posedge pclk);
    if (which == 0) halt_req <= 1; else if (which == 1) ext_irq <= 1; else tb_irq <= 1;
    @(posedge pclk);
    halt_req <= 0; ext_irq <= 0; tb_irq <= 0;
  endtask
  task automatic wait_mode(input logic [1:0] m, input int lim);
    int n;
    n = 0;
    do begin
      apb(0, OFS_STAT, 0);
      n += 3;
    end while (rd[14:13] !== m && n < lim);
    `CHK("mode", m, rd[14:13])
  endtask
  // Polls the counter until it moves away from v; t0 holds the elapsed cycles
  task automatic wait_step(input logic [6:0] v);
    int s;
    s = cyc;
    do apb(0, OFS_CTRL, 0); while (rd[6:0] === v && cyc - s < 20000);
    t0 = cyc - s;
  endtask
  task automatic do_reset();
    @(posedge pclk);
    presetn <= 0;
    repeat (4) @(posedge pclk);
    presetn <= 1;
  endtask
  task automatic end_sim();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #(40 * 90000);
    error_cnt++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    apb(0, OFS_CTRL, 0); `CHK("ctrl_rst", 32'h0000_007f, rd)
    apb(0, OFS_CFG, 0); `CHK("cfg_rst", 32'h0000_0000, rd)
    apb(0, 8'h0c, 0); `CHK("unmapped", 1'b1, err)
    wait_mode(2'd0, 400);
    // Timeout steps with time base 0, count 1, inactive
    apb(1, OFS_CTRL, 32'h0000_0041);
    p0 = pulses;
    wait_step(7'h41); `CHK("first_step", 1'b1, t0 >= 11964 && t0 <= 16390)
    `CHK("dec_inactive", 7'h40, rd[6:0])
    wait_step(7'h40); `CHK("long_step", 1'b1, t0 >= 16060 && t0 <= 16070)
    repeat (3) @(posedge pclk);
    `CHK("no_rst_inactive", p0, pulses)
    // Frozen halt
    apb(0, OFS_CTRL, 0); t0 = rd[6:0];
    pulse_in(0);
    apb(0, OFS_CTRL, 0); `CHK("halt_dec", 7'(t0 - 1), rd[6:0])
    wait_mode(2'd2, 6); `CHK("halt_norst", p0, pulses)
    pulse_in(1);
    wait_mode(2'd3, 6);
    wait_mode(2'd0, 300);
    // Active halt
    apb(1, OFS_CFG, 32'h0000_000c);
    apb(0, OFS_CTRL, 0); t0 = rd[6:0];
    pulse_in(0);
    wait_mode(2'd1, 6);
    repeat (20) @(posedge pclk);
    apb(0, OFS_CTRL, 0); `CHK("ahalt_frozen", t0, 32'(rd[6:0]))
    pulse_in(2);
    wait_mode(2'd0, 3); `CHK("ahalt_norst", p0, pulses)
    // Halt with reset option
    apb(1, OFS_CFG, 32'h0000_0008);
    pulse_in(0);
    repeat (3) @(posedge pclk);
    `CHK("halt_rst", p0 + 1, pulses)
    do_reset();
    wait_mode(2'd0, 400);
    // Activation is set-only; software reset via top bit
    apb(1, OFS_CTRL, 32'h0000_00ff);
    apb(1, OFS_CTRL, 32'h0000_007f);
    apb(0, OFS_CTRL, 0); `CHK("act_sticky", 1'b1, rd[7])
    p0 = pulses;
    apb(1, OFS_CTRL, 32'h0000_00bf);
    repeat (3) @(posedge pclk);
    `CHK("sw_rst", p0 + 1, pulses)
    do_reset();
    apb(0, OFS_CTRL, 0); `CHK("act_clr", 32'h0000_007f, rd)
    apb(0, OFS_STAT, 0); `CHK("start_mode", 2'd3, rd[14:13])
    wait_mode(2'd0, 400);
    // Hardware option makes an inactive watchdog fire
    apb(1, OFS_CFG, 32'h0000_0010);
    apb(1, OFS_CTRL, 32'h0000_003f);
    repeat (3) @(posedge pclk);
    `CHK("hw_rst", p0 + 2, pulses)
    // Frozen halt woken with the long start-up delay
    apb(1, OFS_CFG, 32'h0000_0020);
    pulse_in(0);
    wait_mode(2'd2, 6);
    pulse_in(1);
    repeat (300) @(posedge pclk);
    apb(0, OFS_STAT, 0); `CHK("long_start", 2'd3, rd[14:13])
    wait_mode(2'd0, 4200);
    end_sim();
  end
endmodule
